// *** shared/msq_pkg.sv ***
`default_nettype none
package msq_pkg;
  // Widths
  localparam int WORD_W = 32;
  localparam int DW = 16;
  localparam int MPC_W = 12;
  localparam int RA_W = 4;
  localparam int CTRL_W = 3;
  // Formats in code order of the two top bits
  typedef enum logic [1:0] {FMT_ARITH, FMT_INTB, FMT_JUMP, FMT_LOOP} msq_fmt_t;
  // Field positions
  localparam int OP_HI = 31;
  localparam int OP_LO = 30;
  localparam int LOGIC_BIT = 29;
  localparam int FUNC_HI = 28;
  localparam int FUNC_LO = 25;
  localparam int ALT_HI = 24;
  localparam int ALT_LO = 21;
  localparam int CYC_HI = 24;
  localparam int CYC_LO = 22;
  localparam int DIR_BIT = 20;
  localparam int MRG_HI = 18;
  localparam int MRG_LO = 16;
  localparam int COND_BIT = 15;
  localparam int TST_HI = 14;
  localparam int TST_LO = 12;
  localparam int LVL_HI = 15;
  localparam int LVL_LO = 12;
  localparam int SRC_HI = 11;
  localparam int SRC_LO = 8;
  localparam int IREG_HI = 3;
  localparam int IREG_LO = 0;
  localparam int JC_BIT = 29;
  localparam int JP_BIT = 28;
  localparam int JCAR_BIT = 27;
  localparam int ADR_HI = 11;
  localparam int TERM_HI = 4;
  localparam int TERM_LO = 2;
  localparam int ALTSEL_BIT = 0;
  // Merge field positions
  localparam int MB_UP_HI = 15;
  localparam int MB_UP_LO = 12;
  localparam int IR_UP_HI = 6;
  localparam int IR_UP_LO = 3;
  localparam int MB_FLAG_BIT = 7;
  localparam int IR_LO_HI = 2;
  localparam logic [2:0] MERGE_BITOP_ND = 3'h1;
  // Internal register codes
  localparam logic [3:0] SPECIAL_SRC = 4'hf;
  localparam logic [3:0] IREG_LEVEL = 4'h9;
  localparam logic [3:0] IREG_MEMFLT = 4'hb;
  localparam logic [3:0] IREG_MPC = 4'hc;
  localparam logic [3:0] IREG_IO = 4'he;
  // Arithmetic function codes
  localparam logic [3:0] A_BM1 = 4'h0;
  localparam logic [3:0] A_BMAM1 = 4'h2;
  localparam logic [3:0] A_B = 4'h3;
  localparam logic [3:0] A_PLUSC = 4'h5;
  localparam logic [3:0] A_BMAM1C = 4'h6;
  localparam logic [3:0] A_PLUS = 4'h9;
  localparam logic [3:0] A_PLUS1 = 4'hd;
  localparam logic [3:0] A_BMINA = 4'he;
  localparam logic [3:0] A_BP1 = 4'hf;
  // Retained flag positions {carry, neg, zero}
  localparam int F_ZERO = 0;
  localparam int F_NEG = 1;
  localparam int F_CARRY = 2;
  // Fault and ring
  localparam int FAULT_PRIV_BIT = 6;
  localparam logic [1:0] PRIV_RING_LIMIT = 2'h2;
  // Register offsets and control fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_FAULT = 4'h2;
  localparam int CTRL_INT_EN = 0;
  localparam int CTRL_RING_LO = 1;
  localparam int CTRL_RESUME = 3;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [11:0] MPC_RST = 12'h000;
endpackage
`default_nettype wire

// *** sim/msq_rom_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Control store stand-in: asynchronous read, image loaded by the bench
module msq_rom_model (
  input wire logic [msq_pkg::MPC_W-1:0] rom_addr,
  output logic [msq_pkg::WORD_W-1:0] rom_word
);
  import msq_pkg::*;
  // Program image, one word per counter value
  logic [WORD_W-1:0] mem [0:(1<<MPC_W)-1];
  // Same-cycle answer; the sequencer latches it on the next edge
  always_comb begin
    rom_word = mem[rom_addr];
  end
endmodule
`default_nettype wire

// *** sim/msq_sequencer_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module msq_sequencer_bench;
  import msq_pkg::*;
  // Clock, reset and stimulus
  logic sys_clk, reset_n, shifter_msu_bit15, shifter_lsu_bit0, reg_wr, reg_rd;
  logic [DW-1:0] instr_reg, opnd_a, opnd_b, memory_fault_status, io_input, reg_wdata;
  logic [3:0] current_level_indicator, level_current_q, level_other_q;
  logic [MPC_W-1:0] computed_return_address, rom_addr_q;
  logic [7:0] loop_term_conds;
  logic [RA_W-1:0] reg_addr;
  // Observed outputs
  logic [WORD_W-1:0] rom_word, micro_word_latch_q;
  logic [DW-1:0] alu_result_q, h_path_q, internal_fault_code_q, reg_rdata_q, rd_data;
  logic alu_write_q, dual_alu_q, alt_func_used_q, mem_cycle_start_q, h_path_load_q;
  logic interlevel_read_q, interlevel_write_q, cpu_stop_q;
  logic [2:0] mem_cycle_q;
  // Scoreboard
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic hit_bad = 1'b0;

  msq_rom_model i_msq_rom_model (.rom_addr(rom_addr_q), .rom_word(rom_word));

  msq_sequencer i_msq_sequencer (
    .sys_clk(sys_clk), .reset_n(reset_n), .rom_word(rom_word), .instr_reg(instr_reg),
    .opnd_a(opnd_a), .opnd_b(opnd_b), .current_level_indicator(current_level_indicator),
    .computed_return_address(computed_return_address),
    .memory_fault_status(memory_fault_status), .io_input(io_input),
    .shifter_msu_bit15(shifter_msu_bit15), .shifter_lsu_bit0(shifter_lsu_bit0),
    .loop_term_conds(loop_term_conds), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .rom_addr_q(rom_addr_q),
    .micro_word_latch_q(micro_word_latch_q), .alu_result_q(alu_result_q),
    .alu_write_q(alu_write_q), .dual_alu_q(dual_alu_q), .alt_func_used_q(alt_func_used_q),
    .mem_cycle_q(mem_cycle_q), .mem_cycle_start_q(mem_cycle_start_q), .h_path_q(h_path_q),
    .h_path_load_q(h_path_load_q), .interlevel_read_q(interlevel_read_q),
    .interlevel_write_q(interlevel_write_q), .level_current_q(level_current_q),
    .level_other_q(level_other_q), .cpu_stop_q(cpu_stop_q),
    .internal_fault_code_q(internal_fault_code_q), .reg_rdata_q(reg_rdata_q)
  );

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard; the program needs under a hundred cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // The not-taken branch target must never be fetched
  always @(negedge sys_clk) begin
    if (rom_addr_q === 12'h030) hit_bad <= 1'b1;
  end

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Value comparison
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait, bounded, until the counter shows an address
  task automatic wait_addr(input logic [MPC_W-1:0] a);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (rom_addr_q !== a && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk("rom_addr_q", 32'(a), 32'(rom_addr_q));
  endtask

  // Register port write: one strobe cycle
  task automatic wr(input logic [RA_W-1:0] a, input logic [DW-1:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Register port read: data stands only in the cycle after the strobe
  task automatic rd(input logic [RA_W-1:0] a, output logic [DW-1:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata_q;
  endtask

  // Executed-word results, sampled two counts after the word's address
  task automatic alu_chk(input logic [DW-1:0] r, input logic w, input logic [2:0] mc);
    chk("alu_result_q", 32'(r), 32'(alu_result_q));
    chk("alu_write_q", 32'(w), 32'(alu_write_q));
    chk("mem_cycle_q", 32'(mc), 32'(mem_cycle_q));
    chk("mem_cycle_start_q", 32'(mc != 3'h0), 32'(mem_cycle_start_q));
  endtask

  initial begin
    // Inputs defined at time zero; A=3, B=10 throughout
    {reset_n, reg_wr, reg_rd, shifter_lsu_bit0} = 4'h0;
    shifter_msu_bit15 = 1'b1;
    {reg_addr, reg_wdata, loop_term_conds} = '0;
    instr_reg = 16'h0035;
    opnd_a = 16'h0003;
    opnd_b = 16'h000a;
    current_level_indicator = 4'h7;
    computed_return_address = 12'h060;
    memory_fault_status = 16'h1234;
    io_input = 16'h5678;
    // Program image; unused words are unconditional B-1
    for (int i = 0; i < (1 << MPC_W); i++) i_msq_rom_model.mem[i] = 32'h0000_0000;
    i_msq_rom_model.mem[0] = 32'h12c0_0000;   // B+A, memory cycle 3
    i_msq_rom_model.mem[1] = 32'h3c00_0000;   // Logical B and A
    i_msq_rom_model.mem[2] = 32'h1d40_e000;   // B-A if never, cycle 5
    i_msq_rom_model.mem[3] = 32'h3800_8000;   // Zero if zero
    i_msq_rom_model.mem[4] = 32'h1e00_9000;   // B+1 if nonzero
    i_msq_rom_model.mem[5] = 32'h0000_0f0b;   // Fault status to H
    i_msq_rom_model.mem[6] = 32'h4010_5000;   // Interblock write, level 5
    i_msq_rom_model.mem[7] = 32'h4000_a000;   // Interblock read, level 10
    i_msq_rom_model.mem[8] = 32'h0001_0000;   // Bit-op merge
    i_msq_rom_model.mem[9] = 32'h0001_0000;   // Bit-op merge, zero bit number
    i_msq_rom_model.mem[10] = 32'h8000_0020;  // Jump
    i_msq_rom_model.mem[12'h020] = 32'ha000_6030; // Branch never
    i_msq_rom_model.mem[12'h021] = 32'ha000_7040; // Branch always
    i_msq_rom_model.mem[12'h040] = 32'h9000_0050; // Privileged jump
    i_msq_rom_model.mem[12'h050] = 32'h8800_0000; // Return-address jump
    i_msq_rom_model.mem[12'h060] = 32'hd3c0_0008; // Loop, high shifter bit
    i_msq_rom_model.mem[12'h061] = 32'hd3c0_000d; // Loop, low shifter bit
    i_msq_rom_model.mem[12'h062] = 32'h0000_0f09; // Level to H, stop
    i_msq_rom_model.mem[12'h063] = 32'h1a00_0000; // B+A+1 after resume
    i_msq_rom_model.mem[12'h064] = 32'h0000_0f0c; // Counter to H
    i_msq_rom_model.mem[12'h065] = 32'h0000_0f0e; // I/O input to H
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Straight-line words
    wait_addr(12'h002);
    alu_chk(16'h000d, 1'b1, 3'h3);
    wait_addr(12'h003);
    alu_chk(16'h0002, 1'b1, 3'h0);
    wait_addr(12'h004);
    alu_chk(16'h0002, 1'b0, 3'h5);
    wait_addr(12'h005);
    alu_chk(16'h0002, 1'b0, 3'h0);
    wait_addr(12'h006);
    alu_chk(16'h000b, 1'b1, 3'h0);
    wait_addr(12'h007);
    chk("h_path_q", 32'h1234, 32'(h_path_q));
    chk("h_path_load_q", 32'h1, 32'(h_path_load_q));
    wait_addr(12'h008);
    chk("interlevel_write_q", 32'h1, 32'(interlevel_write_q));
    chk("levels", 32'h75, 32'({level_current_q, level_other_q}));
    // New instruction for the second merge word only
    @(posedge sys_clk);
    instr_reg <= 16'h0030;
    wait_addr(12'h009);
    chk("interlevel_read_q", 32'h1, 32'(interlevel_read_q));
    chk("level_other_q", 32'ha, 32'(level_other_q));
    chk("merged_word", 32'h0001_6005, micro_word_latch_q);
    wait_addr(12'h00a);
    chk("merged_word", 32'h0001_6080, micro_word_latch_q);
    // Jump variants
    wait_addr(12'h020);
    wait_addr(12'h040);
    chk("not_taken_fetch", 32'h0, 32'(hit_bad));
    wait_addr(12'h060);
    chk("internal_fault_code_q", 32'h0040, 32'(internal_fault_code_q));
    // Loop held while its termination input is low
    wait_addr(12'h061);
    repeat (5) @(negedge sys_clk);
    chk("rom_addr_q", 32'h061, 32'(rom_addr_q));
    chk("micro_word_latch_q", 32'hd3c0_0008, micro_word_latch_q);
    chk("dual_alu_q", 32'h1, 32'(dual_alu_q));
    chk("alt_func_used_q", 32'h1, 32'(alt_func_used_q));
    chk("alu_result_q", 32'h0007, 32'(alu_result_q));
    @(posedge sys_clk);
    loop_term_conds <= 8'h04;
    wait_addr(12'h062);
    repeat (3) @(negedge sys_clk);
    chk("alt_func_used_q", 32'h0, 32'(alt_func_used_q));
    chk("alu_result_q", 32'h000d, 32'(alu_result_q));
    @(posedge sys_clk);
    shifter_lsu_bit0 <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("alt_func_used_q", 32'h1, 32'(alt_func_used_q));
    chk("alu_result_q", 32'h0007, 32'(alu_result_q));
    @(posedge sys_clk);
    loop_term_conds <= 8'h08;
    wait_addr(12'h063);
    // Level read with interrupts off stops the processor
    repeat (3) @(negedge sys_clk);
    chk("cpu_stop_q", 32'h1, 32'(cpu_stop_q));
    chk("h_path_q", 32'h0080, 32'(h_path_q));
    rd(REG_STAT, rd_data);
    chk("stat_stop", 32'h1, 32'(rd_data[15]));
    rd(REG_FAULT, rd_data);
    chk("fault_reg", 32'h0040, 32'(rd_data));
    wr(REG_FAULT, 16'h0040);
    rd(REG_FAULT, rd_data);
    chk("fault_reg", 32'h0, 32'(rd_data));
    rd(4'hf, rd_data);
    chk("unmapped", 32'h0, 32'(rd_data));
    // Resume with interrupts on; sequencing carries on
    wr(REG_CTRL, 16'h0009);
    @(negedge sys_clk);
    chk("cpu_stop_q", 32'h0, 32'(cpu_stop_q));
    @(negedge sys_clk);
    chk("alu_result_q", 32'h000e, 32'(alu_result_q));
    @(negedge sys_clk);
    chk("h_path_q", 32'h0065, 32'(h_path_q));
    wait_addr(12'h070);
    chk("h_path_q", 32'h5678, 32'(h_path_q));
    chk("alu_result_q", 32'h0009, 32'(alu_result_q));
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** src/msq_merge.sv ***
`timescale 1ns/100ps
`default_nettype none
module msq_merge (
  input wire logic [msq_pkg::WORD_W-1:0] rom_word,
  input wire logic [msq_pkg::DW-1:0] instr_reg,
  output logic [msq_pkg::WORD_W-1:0] merged_word
);
  import msq_pkg::*;

  // OR logic; only the two formats with a merge field take it
  always_comb begin
    merged_word = rom_word;
    // Specs other than the bit-op one pass the ROM word through
    if (!rom_word[OP_HI] && rom_word[MRG_HI:MRG_LO] == MERGE_BITOP_ND) begin
      merged_word[MB_UP_HI:MB_UP_LO] = instr_reg[IR_UP_HI:IR_UP_LO];
      if (instr_reg[IR_LO_HI:0] != 3'h0) begin
        // Bit number given by the instruction
        merged_word[MB_FLAG_BIT] = 1'b0;
        merged_word[IR_LO_HI:0] = instr_reg[IR_LO_HI:0];
      end else begin
        // Zero bit number flagged, low bits cleared
        merged_word[MB_FLAG_BIT] = 1'b1;
        merged_word[MB_FLAG_BIT-1:0] = 7'h00;
      end
    end
  end
endmodule
`default_nettype wire

// *** src/msq_sequencer.sv ***
`timescale 1ns/100ps
`default_nettype none
module msq_sequencer (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [msq_pkg::WORD_W-1:0] rom_word,
  input wire logic [msq_pkg::DW-1:0] instr_reg,
  input wire logic [msq_pkg::DW-1:0] opnd_a,
  input wire logic [msq_pkg::DW-1:0] opnd_b,
  input wire logic [3:0] current_level_indicator,
  input wire logic [msq_pkg::MPC_W-1:0] computed_return_address,
  input wire logic [msq_pkg::DW-1:0] memory_fault_status,
  input wire logic [msq_pkg::DW-1:0] io_input,
  input wire logic shifter_msu_bit15,
  input wire logic shifter_lsu_bit0,
  input wire logic [7:0] loop_term_conds,
  input wire logic [msq_pkg::RA_W-1:0] reg_addr,
  input wire logic [msq_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [msq_pkg::MPC_W-1:0] rom_addr_q,
  output logic [msq_pkg::WORD_W-1:0] micro_word_latch_q,
  output logic [msq_pkg::DW-1:0] alu_result_q,
  output logic alu_write_q,
  output logic dual_alu_q,
  output logic alt_func_used_q,
  output logic [2:0] mem_cycle_q,
  output logic mem_cycle_start_q,
  output logic [msq_pkg::DW-1:0] h_path_q,
  output logic h_path_load_q,
  output logic interlevel_read_q,
  output logic interlevel_write_q,
  output logic [3:0] level_current_q,
  output logic [3:0] level_other_q,
  output logic cpu_stop_q,
  output logic [msq_pkg::DW-1:0] internal_fault_code_q,
  output logic [msq_pkg::DW-1:0] reg_rdata_q
);
  import msq_pkg::*;

  // Condition tests on retained flags
  function automatic logic cond_test(input logic [2:0] sel, input logic [2:0] f);
    logic r;
    r = 1'b1;
    unique case (sel)
      3'h0: r = f[F_ZERO];
      3'h1: r = !f[F_ZERO];
      3'h2: r = f[F_NEG];
      3'h3: r = !f[F_NEG];
      3'h4: r = f[F_CARRY];
      3'h5: r = !f[F_CARRY];
      3'h6: r = 1'b0;
      3'h7: r = 1'b1;
    endcase
    return r;
  endfunction

  logic [WORD_W-1:0] merged_word; // ROM word after OR logic
  logic [WORD_W-1:0] w; // Executing word
  msq_fmt_t fmt; // Executing format
  logic word_valid_q, word_valid_d; // Low in the bubble after a jump
  logic [2:0] flags_q, flags_d; // Retained high-unit status
  logic [CTRL_W-1:0] ctrl_q, ctrl_d; // {ring, interrupt enable}
  logic [WORD_W-1:0] micro_word_latch_d;
  logic [MPC_W-1:0] rom_addr_d;
  logic [DW-1:0] alu_result_d, h_path_d, internal_fault_code_d, reg_rdata_d;
  logic alu_write_d, dual_alu_d, alt_func_used_d, mem_cycle_start_d;
  logic [2:0] mem_cycle_d;
  logic h_path_load_d, interlevel_read_d, interlevel_write_d, cpu_stop_d;
  logic [3:0] level_current_d, level_other_d;
  logic run, test_ok, exec_alu, looping, alt, jump_taken, priv_hit, lvl_stop;
  logic [3:0] func;
  logic [DW:0] sum; // One carry bit above the result
  logic [DW-1:0] res, fault_clr;

  msq_merge u_merge (
    .rom_word(rom_word),
    .instr_reg(instr_reg),
    .merged_word(merged_word)
  );

  // Decode, ALU, sequencing and register file next values
  always_comb begin
    w = micro_word_latch_q;
    fmt = msq_fmt_t'(w[OP_HI:OP_LO]);
    run = word_valid_q && !cpu_stop_q;
    // Previous result's status, never the current one
    test_ok = cond_test(w[TST_HI:TST_LO], flags_q);
    // Conditional arithmetic drops only the ALU part
    exec_alu = run && fmt != FMT_JUMP
      && !(fmt == FMT_ARITH && w[COND_BIT] && !test_ok);
    looping = run && fmt == FMT_LOOP
      && !loop_term_conds[w[TERM_HI:TERM_LO]];
    // Alternative select source picked by loop bit 0
    alt = fmt == FMT_LOOP
      && (w[ALTSEL_BIT] ? shifter_lsu_bit0 : shifter_msu_bit15);
    func = alt ? w[ALT_HI:ALT_LO] : w[FUNC_HI:FUNC_LO];
    jump_taken = run && fmt == FMT_JUMP && (!w[JC_BIT] || test_ok);
    priv_hit = run && fmt == FMT_JUMP && w[JP_BIT]
      && ctrl_q[CTRL_RING_LO+:2] < PRIV_RING_LIMIT;
    lvl_stop = run && fmt == FMT_ARITH && w[SRC_HI:SRC_LO] == SPECIAL_SRC
      && w[IREG_HI:IREG_LO] == IREG_LEVEL && !ctrl_q[CTRL_INT_EN];

    // ALU, mode from bit 29
    sum = {1'b0, opnd_b};
    if (w[LOGIC_BIT]) begin
      unique case (func)
        4'h0: res = ~opnd_b;
        4'h1: res = ~(opnd_b | opnd_a);
        4'h2: res = ~opnd_b | opnd_a;
        4'h3: res = 16'hffff;
        4'h4: res = ~(opnd_b & opnd_a);
        4'h5: res = ~opnd_a;
        4'h6: res = ~(opnd_b ^ opnd_a);
        4'h7: res = opnd_b | ~opnd_a;
        4'h8: res = ~opnd_b & opnd_a;
        4'h9: res = opnd_b ^ opnd_a;
        4'ha: res = opnd_a;
        4'hb: res = opnd_b | opnd_a;
        4'hc: res = 16'h0000;
        4'hd: res = opnd_b & ~opnd_a;
        4'he: res = opnd_b & opnd_a;
        4'hf: res = opnd_b;
      endcase
    end else begin
      // Undefined arithmetic codes pass B
      case (func)
        A_BM1: sum = {1'b0, opnd_b} - 17'h1;
        A_BMAM1: sum = {1'b0, opnd_b} - {1'b0, opnd_a} - 17'h1;
        A_B: sum = {1'b0, opnd_b};
        A_PLUSC: sum = {1'b0, opnd_b} + {1'b0, opnd_a} + {16'h0, flags_q[F_CARRY]};
        A_BMAM1C: sum = {1'b0, opnd_b} - {1'b0, opnd_a} - 17'h1
          + {16'h0, flags_q[F_CARRY]};
        A_PLUS: sum = {1'b0, opnd_b} + {1'b0, opnd_a};
        A_PLUS1: sum = {1'b0, opnd_b} + {1'b0, opnd_a} + 17'h1;
        A_BMINA: sum = {1'b0, opnd_b} - {1'b0, opnd_a};
        A_BP1: sum = {1'b0, opnd_b} + 17'h1;
        default: sum = {1'b0, opnd_b};
      endcase
      res = sum[DW-1:0];
    end

    // Result and retained status only when executed
    alu_write_d = exec_alu;
    alu_result_d = exec_alu ? res : alu_result_q;
    flags_d = exec_alu ? {sum[DW] & !w[LOGIC_BIT], res[DW-1], res == 16'h0000}
      : flags_q;
    dual_alu_d = run && fmt == FMT_LOOP;
    alt_func_used_d = run && alt;

    // Memory cycle even when the test fails
    mem_cycle_d = (run && fmt == FMT_ARITH) ? w[CYC_HI:CYC_LO] : 3'h0;
    mem_cycle_start_d = mem_cycle_d != 3'h0;

    // Internal register onto the H path
    h_path_load_d = run && fmt == FMT_ARITH && w[SRC_HI:SRC_LO] == SPECIAL_SRC;
    h_path_d = h_path_q;
    if (h_path_load_d) begin
      case (w[IREG_HI:IREG_LO])
        IREG_LEVEL: h_path_d = 16'h0001 << current_level_indicator;
        IREG_MEMFLT: h_path_d = memory_fault_status;
        IREG_MPC: h_path_d = {4'h0, rom_addr_q};
        IREG_IO: h_path_d = io_input;
        default: h_path_d = 16'h0000;
      endcase
    end

    // Interlevel transfer between current and named level
    interlevel_write_d = run && fmt == FMT_INTB && w[DIR_BIT];
    interlevel_read_d = run && fmt == FMT_INTB && !w[DIR_BIT];
    level_current_d = current_level_indicator;
    level_other_d = w[LVL_HI:LVL_LO];

    // Sequencing; default is next word and plus one
    micro_word_latch_d = merged_word;
    rom_addr_d = rom_addr_q + 12'h001;
    word_valid_d = 1'b1;
    if (cpu_stop_q) begin
      // Stopped: everything stands
      micro_word_latch_d = micro_word_latch_q;
      rom_addr_d = rom_addr_q;
      word_valid_d = word_valid_q;
    end else if (looping) begin
      micro_word_latch_d = micro_word_latch_q;
      rom_addr_d = rom_addr_q;
    end else if (jump_taken) begin
      // Word fetched behind the jump is a bubble
      rom_addr_d = w[JCAR_BIT] ? computed_return_address
        : w[ADR_HI:0];
      word_valid_d = 1'b0;
    end

    // Register file; hardware set wins over software clear
    ctrl_d = ctrl_q;
    if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_d = reg_wdata[CTRL_W-1:0];
    end
    cpu_stop_d = lvl_stop
      || (cpu_stop_q && !(reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RESUME]));
    fault_clr = (reg_wr && reg_addr == REG_FAULT) ? reg_wdata : 16'h0000;
    internal_fault_code_d = internal_fault_code_q & ~fault_clr;
    internal_fault_code_d[FAULT_PRIV_BIT] = priv_hit
      || internal_fault_code_d[FAULT_PRIV_BIT];
    reg_rdata_d = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata_d = {13'h0000, ctrl_q};
        REG_STAT: reg_rdata_d = {cpu_stop_q, word_valid_q, 2'h0, rom_addr_q};
        REG_FAULT: reg_rdata_d = internal_fault_code_q;
        default: reg_rdata_d = 16'h0000;
      endcase
    end
  end

  // All state and outputs, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rom_addr_q <= MPC_RST;
      micro_word_latch_q <= 32'h0000_0000;
      word_valid_q <= 1'b0;
      flags_q <= 3'h0;
      ctrl_q <= CTRL_RST;
      alu_result_q <= 16'h0000;
      alu_write_q <= 1'b0;
      dual_alu_q <= 1'b0;
      alt_func_used_q <= 1'b0;
      mem_cycle_q <= 3'h0;
      mem_cycle_start_q <= 1'b0;
      h_path_q <= 16'h0000;
      h_path_load_q <= 1'b0;
      interlevel_read_q <= 1'b0;
      interlevel_write_q <= 1'b0;
      level_current_q <= 4'h0;
      level_other_q <= 4'h0;
      cpu_stop_q <= 1'b0;
      internal_fault_code_q <= 16'h0000;
      reg_rdata_q <= 16'h0000;
    end else begin
      rom_addr_q <= rom_addr_d;
      micro_word_latch_q <= micro_word_latch_d;
      word_valid_q <= word_valid_d;
      flags_q <= flags_d;
      ctrl_q <= ctrl_d;
      alu_result_q <= alu_result_d;
      alu_write_q <= alu_write_d;
      dual_alu_q <= dual_alu_d;
      alt_func_used_q <= alt_func_used_d;
      mem_cycle_q <= mem_cycle_d;
      mem_cycle_start_q <= mem_cycle_start_d;
      h_path_q <= h_path_d;
      h_path_load_q <= h_path_load_d;
      interlevel_read_q <= interlevel_read_d;
      interlevel_write_q <= interlevel_write_d;
      level_current_q <= level_current_d;
      level_other_q <= level_other_d;
      cpu_stop_q <= cpu_stop_d;
      internal_fault_code_q <= internal_fault_code_d;
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_LOAD_EACH: assert property (
    (!looping && !cpu_stop_q) |=> micro_word_latch_q == $past(merged_word))
    else $error("Microword not loaded from ROM");
  AST_LOOP_HOLD: assert property (
    (looping && !cpu_stop_q) |=> $stable(micro_word_latch_q) && $stable(rom_addr_q))
    else $error("Loop word or counter moved");
  AST_INCR: assert property (
    (!cpu_stop_q && !looping && !jump_taken)
    |=> rom_addr_q == 12'($past(rom_addr_q) + 12'h001))
    else $error("Counter did not advance by one");
  AST_JUMP_ABS: assert property (
    (jump_taken && !w[JCAR_BIT]) |=> rom_addr_q == $past(w[ADR_HI:0]) && !word_valid_q)
    else $error("Absolute jump target wrong");
  AST_JUMP_CAR: assert property (
    (jump_taken && w[JCAR_BIT]) |=> rom_addr_q == $past(computed_return_address))
    else $error("Return jump target wrong");
  AST_COND_SUPPRESS: assert property (
    (run && fmt == FMT_ARITH && w[COND_BIT] && !test_ok)
    |=> !alu_write_q && mem_cycle_q == $past(w[CYC_HI:CYC_LO]))
    else $error("False test not handled");
  AST_PRIV: assert property (
    priv_hit |=> internal_fault_code_q[FAULT_PRIV_BIT] ##1 internal_fault_code_q[FAULT_PRIV_BIT]
      || $past(reg_wr))
    else $error("Privileged fault not raised");
  AST_STOP: assert property (
    lvl_stop |=> cpu_stop_q ##1 (cpu_stop_q || $past(reg_wr)))
    else $error("Level read did not stop");
  AST_ALT: assert property (
    (run && fmt == FMT_LOOP && !w[ALTSEL_BIT] && shifter_msu_bit15) |=> alt_func_used_q)
    else $error("Alternative select missed");
  AST_IB_DIR: assert property (
    (run && fmt == FMT_INTB) |=> interlevel_write_q == $past(w[DIR_BIT])
      && interlevel_read_q != interlevel_write_q && level_other_q == $past(w[LVL_HI:LVL_LO]))
    else $error("Interblock direction wrong");
  // Loop words drive both units and may pick the low shifter bit
  AST_ALT_LOW: assert property (
    (run && fmt == FMT_LOOP && w[ALTSEL_BIT] && shifter_lsu_bit0) |=> alt_func_used_q)
    else $error("Low shifter select missed");
  AST_DUAL: assert property (
    (run && fmt == FMT_LOOP) |=> dual_alu_q)
    else $error("Loop word did not drive both units");
  AST_LOOP_EXIT: assert property (
    (run && fmt == FMT_LOOP && !looping) |=> rom_addr_q == 12'($past(rom_addr_q) + 12'h001))
    else $error("Counter did not resume after loop");
  // A false conditional jump falls through to the next word
  AST_JUMP_SKIP: assert property (
    (run && fmt == FMT_JUMP && w[JC_BIT] && !test_ok)
    |=> rom_addr_q == 12'($past(rom_addr_q) + 12'h001) && word_valid_q)
    else $error("Untaken jump moved the counter");
  // Cycle field reaches the memory side whatever the test says
  AST_MEM_CYCLE: assert property (
    (run && fmt == FMT_ARITH)
    |=> mem_cycle_q == $past(w[CYC_HI:CYC_LO]) && mem_cycle_start_q == (mem_cycle_q != 3'h0))
    else $error("Memory cycle not launched");
  // Only the fault status source is watched; the others share the path
  AST_H_FAULT: assert property (
    (run && fmt == FMT_ARITH && w[SRC_HI:SRC_LO] == SPECIAL_SRC
      && w[IREG_HI:IREG_LO] == IREG_MEMFLT)
    |=> h_path_load_q && h_path_q == $past(memory_fault_status))
    else $error("Fault status not on H path");
  AST_LEVELS: assert property (
    (run && fmt == FMT_INTB) |=> level_current_q == $past(current_level_indicator))
    else $error("Interblock current level wrong");
  // Sum checked against the operands, not against the case table
  AST_PLUS: assert property (
    (exec_alu && !w[LOGIC_BIT] && func == A_PLUS)
    |=> alu_result_q == 16'($past(opnd_b) + $past(opnd_a)))
    else $error("B plus A result wrong");
  // Merged upper field comes from the instruction register
  AST_MERGE_UP: assert property (
    (!cpu_stop_q && !looping && !rom_word[OP_HI] && rom_word[MRG_HI:MRG_LO] == MERGE_BITOP_ND)
    |=> micro_word_latch_q[MB_UP_HI:MB_UP_LO] == $past(instr_reg[IR_UP_HI:IR_UP_LO]))
    else $error("Merge upper field wrong");

  COV_LOOP: cover property (looping [*3] ##1 !looping);
  COV_JUMP: cover property (jump_taken ##2 word_valid_q);
  COV_SUPPRESS: cover property (run && w[COND_BIT] && fmt == FMT_ARITH && !test_ok);
  COV_STOP: cover property (lvl_stop ##1 cpu_stop_q);
  COV_ALT_LOW: cover property (run && fmt == FMT_LOOP && w[ALTSEL_BIT] && shifter_lsu_bit0);
endmodule
`default_nettype wire
